// *** tb_three_wire_serial_master_tx.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_three_wire_serial_master_tx;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, smp_lvl = 1;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, sclk, sdo, sdo_oe, irq, er;
	logic [3:0] ch_output_enable;
	logic [7:0] rx_word;
	int bit_cnt, n0, err_total = 0, checked = 0, cyc = 0;
	always #4 pclk = ~pclk;
	tws_master_tx i_tws_master_tx (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sclk, .sdo, .sdo_oe, .ch_output_enable, .irq);
	// An undriven data line shows the inverse, so a word sent without enable is caught
	tws_slave_model i_tws_slave_model (.sclk, .sdo(sdo_oe ? sdo : ~sdo), .sample_level(smp_lvl),
		.rx_word, .bit_cnt);
	// ----------------------------------------
	// Bus and wait helpers
	// ----------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
			err_total++;
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Extra cycles after the word catch any word sent twice
	task wait_bits(input int n);
		int k;
		k = 0;
		while (bit_cnt - n0 < n && k < 2000)
		begin
			@(posedge pclk);
			k++;
		end
		if (k == 2000)
			err_total++;
		repeat (60) @(posedge pclk);
	endtask
	task print_verdict;
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		logic [7:0] ra [5] = '{`TWS_OFF_MODE, `TWS_OFF_LEVEL, `TWS_OFF_OE, 8'h20, 8'h08};
		logic [31:0] rv [5] = '{32'h10, 32'h3, 32'h0, 32'h0, 32'h0};
		`CHK("idle pins", 3'b110, {sclk, sdo, sdo_oe})
		for (int i = 0; i < 5; i++)
		begin
			apb(0, ra[i], 0);
			`CHK("reset value", rv[i], rd)
		end
	endtask
	task t_init;
		apb(1, `TWS_OFF_OE, 32'hffff);
		apb(0, `TWS_OFF_OE, 0);
		`CHK("oe width", 32'hf, rd)
		`CHK("sdo_oe", 1'b1, sdo_oe)
		apb(1, `TWS_OFF_START, 1);
		apb(0, `TWS_OFF_STATUS, 0);
		`CHK("operating", 1'b1, rd[0])
		apb(0, 8'h40, 0);
		`CHK("unmapped", 33'h100000000, {er, rd})
	endtask
	task t_word(input logic [15:0] m, input logic [7:0] b);
		logic [7:0] e, k;
		apb(1, `TWS_OFF_MODE, {16'h0, m});
		apb(1, `TWS_OFF_LEVEL, {30'h0, ~m[2], 1'b1});
		smp_lvl <= m[1] ? m[2] : ~m[2];
		repeat (2) @(posedge pclk);
		n0 = bit_cnt;
		apb(1, `TWS_OFF_DATA, {24'h0, b});
		wait_bits(m[4] ? 8 : 7);
		if (m[3])
			e = {<<{b}};
		else
			e = b;
		k = m[4] ? 8'hff : 8'h7f;
		`CHK("word", e & k, rx_word & k)
		`CHK("bit count", m[4] ? 8 : 7, bit_cnt - n0)
		`CHK("sclk idle", ~m[2], sclk)
	endtask
	task t_modes;
		logic [15:0] mt [6] = '{16'h0110, 16'h0118, 16'h0100, 16'h0114, 16'h0112, 16'h0116};
		for (int i = 0; i < 6; i++)
			t_word(mt[i], 8'hc5 + i);
	endtask
	task t_over;
		n0 = bit_cnt;
		apb(1, `TWS_OFF_DATA, 32'h11);
		apb(1, `TWS_OFF_DATA, 32'h22);
		apb(1, `TWS_OFF_DATA, 32'h33);
		wait_bits(16);
		`CHK("overwrite", 8'h33, rx_word)
		`CHK("word count", 16, bit_cnt - n0)
	endtask
	task t_irq;
		apb(1, 8'h20, 1);
		// Earlier words left the end bit set; clear it so this word must set it again
		apb(0, 8'h1c, 0);
		n0 = bit_cnt;
		apb(1, `TWS_OFF_DATA, 32'h5a);
		wait_bits(8);
		`CHK("end irq", 1'b1, irq)
		apb(0, 8'h1c, 0);
		repeat (2) @(posedge pclk);
		`CHK("read clear", 3'b010, {rd[1:0], irq})
		apb(1, `TWS_OFF_MODE, 32'h0111);
		apb(1, 8'h20, 3);
		n0 = bit_cnt;
		apb(1, `TWS_OFF_DATA, 32'ha5);
		repeat (4) @(posedge pclk);
		`CHK("empty irq", 1'b1, irq)
		apb(0, 8'h1c, 0);
		`CHK("empty stat", 2'b10, rd[1:0])
		apb(1, `TWS_OFF_MODE, 32'h0110);
		wait_bits(8);
		apb(0, 8'h1c, 0);
		`CHK("late select", 2'b01, rd[1:0])
		apb(1, 8'h20, 0);
		apb(1, `TWS_OFF_DATA, 32'h3c);
		wait_bits(8);
		`CHK("masked", 1'b0, irq)
	endtask
	task t_stop;
		apb(1, `TWS_OFF_DATA, 32'hff);
		repeat (10) @(posedge pclk);
		apb(1, `TWS_OFF_STOP, 1);
		repeat (3) @(posedge pclk);
		`CHK("stop sclk", 1'b0, sclk)
		apb(0, `TWS_OFF_STATUS, 0);
		`CHK("stopped", 3'b000, rd[2:0])
		n0 = bit_cnt;
		apb(1, `TWS_OFF_DATA, 32'h0f);
		repeat (100) @(posedge pclk);
		`CHK("no word", 0, bit_cnt - n0)
		apb(1, `TWS_OFF_OE, 0);
		apb(1, `TWS_OFF_LEVEL, 0);
		repeat (2) @(posedge pclk);
		`CHK("pins off", 3'b000, {sclk, sdo, sdo_oe})
	endtask
	// Deep sleep: reset the unit while it is stopped, then set it up again from scratch
	task t_sleep;
		presetn <= 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		`CHK("reset pins", 3'b110, {sclk, sdo, sdo_oe})
		@(posedge pclk);
		`CHK("reset pins 2", 3'b110, {sclk, sdo, sdo_oe})
		apb(0, `TWS_OFF_STATUS, 0);
		`CHK("reset status", 3'b000, rd[2:0])
		apb(1, `TWS_OFF_OE, 1);
		apb(1, `TWS_OFF_START, 1);
		n0 = bit_cnt;
		apb(1, `TWS_OFF_DATA, 32'h96);
		wait_bits(8);
		`CHK("word after reset", 8'h96, rx_word)
		`CHK("count after reset", 8, bit_cnt - n0)
	endtask
	// ----------------------------------------
	// Hang guard and main sequence
	// ----------------------------------------
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			print_verdict;
		end
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset;
		t_init;
		t_modes;
		t_over;
		t_irq;
		t_stop;
		t_sleep;
		print_verdict;
	end
endmodule // tb_three_wire_serial_master_tx
`default_nettype wire

// *** tws_bit_pick.v ***
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.vh"
// ----------------------------------------------------------------
// Picks the bit sent in a given slot of a 7 or 8 bit word
// ----------------------------------------------------------------
module tws_bit_pick (
	input wire [7:0] word,
	input wire [2:0] idx,
	input wire lsb_first,
	input wire len8,
	output wire bit_out
);
	wire [2:0] top;
	wire [2:0] pos;

	// MSB first counts down from the word's top bit
	assign top = len8 ? `TWS_LAST_BIT8 : `TWS_LAST_BIT7;
	assign pos = lsb_first ? idx : (top - idx);
	assign bit_out = word[pos];
endmodule // tws_bit_pick
`default_nettype wire

// *** tws_half_tick.v ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Half bit period tick from the programmed divisor
// ----------------------------------------------------------------
module tws_half_tick (
	input wire pclk,
	input wire presetn,
	input wire run,
	input wire [7:0] div,
	output wire tick
);
	reg [7:0] cnt;

	// Tick every div+1 cycles while running; restart from zero when stopped
	assign tick = run & (cnt == div);

	// Counter held at zero outside a word so each word starts a full half
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt <= 8'h00;
		else if (!run || tick)
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
	end
endmodule // tws_half_tick
`default_nettype wire

// *** tws_map.vh ***
// ----------------------------------------------------------------
// Register map and field layout of the three-wire serial transmitter
// ----------------------------------------------------------------
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// ----------------------------------------------------------------
// Byte offsets on the APB
// ----------------------------------------------------------------
`define TWS_OFF_MODE 8'h00
`define TWS_OFF_DATA 8'h04
`define TWS_OFF_STATUS 8'h08
`define TWS_OFF_START 8'h0c
`define TWS_OFF_STOP 8'h10
`define TWS_OFF_LEVEL 8'h14
`define TWS_OFF_OE 8'h18
`define TWS_OFF_IRQ_STAT 8'h1c
`define TWS_OFF_IRQ_MASK 8'h20

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define TWS_MODE_W 16
`define TWS_MODE_IRQSEL 0
`define TWS_MODE_DAP 1
`define TWS_MODE_CKP 2
`define TWS_MODE_LSB 3
`define TWS_MODE_LEN8 4
`define TWS_MODE_DIV_LO 8
`define TWS_MODE_DIV_HI 15
`define TWS_MODE_RESET 16'h0010

// ----------------------------------------------------------------
// Idle level, output enable, status and trigger fields
// ----------------------------------------------------------------
`define TWS_LEVEL_W 2
`define TWS_LEVEL_SDO 0
`define TWS_LEVEL_SCLK 1
`define TWS_LEVEL_RESET 2'h3
`define TWS_OE_W 4
`define TWS_OE_RESET 4'h0
`define TWS_OE_CH 0
`define TWS_ST_OPER 0
`define TWS_ST_BUFF 1
`define TWS_ST_BUSY 2
`define TWS_TRIG_BIT 0

// ----------------------------------------------------------------
// Interrupt sources: one status and mask bit each
// ----------------------------------------------------------------
`define TWS_IRQ_W 2
`define TWS_IRQ_END 0
`define TWS_IRQ_EMPTY 1
`define TWS_IRQ_RESET 2'h0

// ----------------------------------------------------------------
// Word length and states
// ----------------------------------------------------------------
`define TWS_LAST_BIT8 3'h7
`define TWS_LAST_BIT7 3'h6
`define TWS_ST_IDLE 3'h1
`define TWS_ST_LEAD 3'h2
`define TWS_ST_SHIFT 3'h4

`endif

// *** tws_master_tx.v ***
//Function
// - Before start, clock and data pins show their programmed idle levels.
// - Output enable bit 1 lets the channel drive data; 0 stops it.
// - Output enable holds one bit per channel in 3..0; upper bits read zero.
// - Writing 1 to the start trigger sets the operating flag.
// - While operating, writing the low data byte starts a transfer.
// - Writing 1 to the stop trigger clears the operating flag.
// - A data write while the buffer is full overwrites the pending byte.
// - Interrupt source select stays writable; it is taken at load for buffer empty and at word end for transfer end.
// - Data phase 0 starts data with the clock; 1 starts it half earlier.
// - Clock phase 0 gives positive clock, 1 the inverted clock.
// - Raise transfer end in single mode or buffer empty in continuous mode.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.vh"
module tws_master_tx (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg sclk,
	output reg sdo,
	output reg sdo_oe,
	output reg [3:0] ch_output_enable,
	output reg irq
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	reg [15:0] mode;
	reg [1:0] out_level;
	reg operating;
	reg [7:0] buf_data;
	reg buffer_full;
	reg [7:0] shift_word;
	reg [2:0] bit_idx;
	reg half;
	reg [2:0] state;
	reg [1:0] irq_stat;
	reg [1:0] irq_mask;
	reg [1:0] events;
	reg [31:0] rd_value;
	reg hit;
	wire setup;
	wire access_done;
	wire wr;
	wire rd;
	wire tick;
	wire run;
	wire load;
	wire pick_bit;
	wire [2:0] pick_idx;
	wire [2:0] last_bit;
	wire dap;
	wire ckp;
	wire busy;
	wire stat_clear;

	// ----------------------------------------------------------------
	// APB phases
	// ----------------------------------------------------------------
	// Access completes on the edge where pready is seen high
	assign setup = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr = access_done & pwrite;
	assign rd = access_done & ~pwrite;
	assign stat_clear = rd & (paddr == `TWS_OFF_IRQ_STAT);

	// Read mux; reserved bits and trigger registers read as zero
	always @*
	begin
		rd_value = 32'h00000000;
		hit = 1'b1;
		case (paddr)
			`TWS_OFF_MODE:
				rd_value[15:0] = mode;
			`TWS_OFF_DATA:
				rd_value[7:0] = buf_data;
			`TWS_OFF_STATUS:
			begin
				rd_value[`TWS_ST_OPER] = operating;
				rd_value[`TWS_ST_BUFF] = buffer_full;
				rd_value[`TWS_ST_BUSY] = busy;
			end
			`TWS_OFF_START:
				rd_value = 32'h00000000;
			`TWS_OFF_STOP:
				rd_value = 32'h00000000;
			`TWS_OFF_LEVEL:
				rd_value[1:0] = out_level;
			`TWS_OFF_OE:
				rd_value[3:0] = ch_output_enable;
			`TWS_OFF_IRQ_STAT:
				rd_value[1:0] = irq_stat;
			`TWS_OFF_IRQ_MASK:
				rd_value[1:0] = irq_mask;
			default:
				hit = 1'b0;
		endcase
	end

	// Registered answer: no wait state, pready is high in the first access cycle, and every bus output is a flop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup)
				prdata <= rd_value;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Mode stays writable while running; the source select is read at load for empty and at word end for end
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode <= `TWS_MODE_RESET;
			out_level <= `TWS_LEVEL_RESET;
			ch_output_enable <= `TWS_OE_RESET;
			sdo_oe <= 1'b0;
			irq_mask <= `TWS_IRQ_RESET;
		end
		else if (wr)
		begin
			case (paddr)
				`TWS_OFF_MODE:
					mode <= pwdata[15:0];
				`TWS_OFF_LEVEL:
					out_level <= pwdata[1:0];
				`TWS_OFF_OE:
				begin
					ch_output_enable <= pwdata[3:0];
					sdo_oe <= pwdata[`TWS_OE_CH];
				end
				`TWS_OFF_IRQ_MASK:
					irq_mask <= pwdata[1:0];
				default:
					irq_mask <= irq_mask;
			endcase
		end
	end

	// Operating flag from the start and stop triggers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			operating <= 1'b0;
		else if (wr && paddr == `TWS_OFF_START && pwdata[`TWS_TRIG_BIT])
			operating <= 1'b1;
		else if (wr && paddr == `TWS_OFF_STOP && pwdata[`TWS_TRIG_BIT])
			operating <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Transmit buffer
	// ----------------------------------------------------------------
	// A write in the load cycle wins, so the new byte stays pending
	assign load = (state == `TWS_ST_IDLE) & operating & buffer_full;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_data <= 8'h00;
			buffer_full <= 1'b0;
		end
		else if (wr && paddr == `TWS_OFF_DATA && operating)
		begin
			buf_data <= pwdata[7:0];
			buffer_full <= 1'b1;
		end
		else if (load || !operating)
			buffer_full <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Shift engine
	// ----------------------------------------------------------------
	assign dap = mode[`TWS_MODE_DAP];
	assign ckp = mode[`TWS_MODE_CKP];
	assign busy = (state != `TWS_ST_IDLE);
	assign last_bit = mode[`TWS_MODE_LEN8] ? `TWS_LAST_BIT8 : `TWS_LAST_BIT7;
	assign pick_idx = (state == `TWS_ST_SHIFT) ? (bit_idx + 3'h1) : 3'h0;
	// The lead half only counts time when data goes out early
	assign run = (state == `TWS_ST_SHIFT) | ((state == `TWS_ST_LEAD) & dap);

	tws_half_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.div(mode[`TWS_MODE_DIV_HI:`TWS_MODE_DIV_LO]),
		.tick(tick)
	);

	tws_bit_pick u_pick (
		.word(shift_word),
		.idx(pick_idx),
		.lsb_first(mode[`TWS_MODE_LSB]),
		.len8(mode[`TWS_MODE_LEN8]),
		.bit_out(pick_bit)
	);

	// Stop is immediate: an urgent stop cuts the word and restores idle levels
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= `TWS_ST_IDLE;
			shift_word <= 8'h00;
			bit_idx <= 3'h0;
			half <= 1'b0;
			sclk <= 1'b1;
			sdo <= 1'b1;
			events <= `TWS_IRQ_RESET;
		end
		else
		begin
			events <= `TWS_IRQ_RESET;
			if (!operating)
			begin
				state <= `TWS_ST_IDLE;
				half <= 1'b0;
				bit_idx <= 3'h0;
				sclk <= out_level[`TWS_LEVEL_SCLK];
				sdo <= out_level[`TWS_LEVEL_SDO];
			end
			else
			begin
				case (state)
					`TWS_ST_IDLE:
					begin
						sclk <= out_level[`TWS_LEVEL_SCLK];
						if (load)
						begin
							shift_word <= buf_data;
							bit_idx <= 3'h0;
							half <= 1'b0;
							state <= `TWS_ST_LEAD;
							events[`TWS_IRQ_EMPTY] <= mode[`TWS_MODE_IRQSEL];
						end
					end
					`TWS_ST_LEAD:
					begin
						sdo <= pick_bit;
						// Early data waits one half period before the clock runs
						if (!dap || tick)
						begin
							state <= `TWS_ST_SHIFT;
							sclk <= ckp;
						end
					end
					`TWS_ST_SHIFT:
					begin
						if (tick && !half)
						begin
							half <= 1'b1;
							sclk <= ~ckp;
							if (dap && bit_idx != last_bit)
								sdo <= pick_bit;
						end
						else if (tick && half)
						begin
							if (bit_idx == last_bit)
							begin
								state <= `TWS_ST_IDLE;
								half <= 1'b0;
								sclk <= out_level[`TWS_LEVEL_SCLK];
								events[`TWS_IRQ_END] <= ~mode[`TWS_MODE_IRQSEL];
							end
							else
							begin
								half <= 1'b0;
								bit_idx <= bit_idx + 3'h1;
								sclk <= ckp;
								if (!dap)
									sdo <= pick_bit;
							end
						end
					end
					default:
						state <= `TWS_ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and output
	// ----------------------------------------------------------------
	// Only bits shown to the read are cleared, so a late event survives
	genvar gi;
	generate
		for (gi = 0; gi < `TWS_IRQ_W; gi = gi + 1)
		begin : g_irq
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					irq_stat[gi] <= 1'b0;
				else
					irq_stat[gi] <= events[gi] | (irq_stat[gi] & ~(stat_clear & prdata[gi]));
			end
		end
	endgenerate

	// Level interrupt, one cycle behind the status bits
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & irq_mask);
	end
endmodule // tws_master_tx
`default_nettype wire

// *** tws_master_tx_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks of the serial transmitter
// ----------------------------------------
module tws_master_tx_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic [3:0] ch_output_enable,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup cycle and the accesses built on it
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wr_oe;
		s_setup ##1 (pready && pwrite && paddr == 8'h18);
	endsequence
	sequence s_rd_oe;
		s_setup ##0 (!pwrite && paddr == 8'h18);
	endsequence
	sequence s_bad;
		s_setup ##0 (paddr > 8'h20);
	endsequence
	property p_rdy_next;
		s_setup |=> pready;
	endproperty
	property p_rdy_one;
		pready |=> !pready;
	endproperty
	property p_err_bad;
		s_bad |=> pslverr && prdata == 32'h0;
	endproperty
	property p_err_only;
		pslverr |-> pready && paddr > 8'h20;
	endproperty
	property p_oe_wr;
		s_wr_oe |=> ch_output_enable == $past(pwdata[3:0]);
	endproperty
	property p_oe_rd;
		s_rd_oe |=> prdata == {28'h0, ch_output_enable};
	endproperty
	property p_oe_on;
		ch_output_enable[0] |-> ##[0:1] sdo_oe;
	endproperty
	property p_oe_off;
		!ch_output_enable[0] |-> ##[0:1] !sdo_oe;
	endproperty
	a_rdy_next: assert property (p_rdy_next) else $error("pready late");
	a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
	a_err_bad: assert property (p_err_bad) else $error("unmapped not refused");
	a_err_only: assert property (p_err_only) else $error("spurious pslverr");
	a_oe_wr: assert property (p_oe_wr) else $error("enable write lost");
	a_oe_rd: assert property (p_oe_rd) else $error("enable read wrong");
	a_oe_on: assert property (p_oe_on) else $error("data not driven");
	a_oe_off: assert property (p_oe_off) else $error("data still driven");
endmodule // tws_master_tx_checker
bind tws_master_tx tws_master_tx_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .sclk, .sdo, .sdo_oe, .ch_output_enable, .irq);
`default_nettype wire

// *** tws_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Receiving slave on the serial link
// ----------------------------------------
module tws_slave_model (
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sample_level,
	output logic [7:0] rx_word,
	output int bit_cnt
);
	initial bit_cnt = 0;
	// Takes a bit on every clock edge that reaches the sampling level
	// The bench works on count differences, so a start-up edge does no harm
	always @(sclk)
	begin
		if (sclk === sample_level)
		begin
			rx_word <= {rx_word[6:0], sdo};
			bit_cnt <= bit_cnt + 1;
		end
	end
endmodule // tws_slave_model
`default_nettype wire
